//--- bst_pkg.sv
// bst_pkg: constants, instruction codes, carriers and decode for the boundary-scan test port.
// assumes one clk_sys domain; the test port pins arrive asynchronously and are synchronised.
package bst_pkg;

    // pin counts of the scanned pad ring
    localparam int BST_NB        = 4;   // bidirectional pins, pin 0 is the general-purpose pin
    localparam int BST_NI        = 2;   // input-only pins
    localparam int BST_NO        = 2;   // tri-state output pins
    localparam int BST_CHAIN_LEN = 2 * BST_NB + BST_NI + BST_NO;
    localparam int BST_IN_BASE   = 2 * BST_NB;
    localparam int BST_OUT_BASE  = 2 * BST_NB + BST_NI;

    localparam int BST_IR_W = 5;
    localparam int BST_ID_W = 32;

    // instruction codes
    localparam logic [BST_IR_W-1:0] BST_OP_EXTEST   = 5'h00;
    localparam logic [BST_IR_W-1:0] BST_OP_SAMPLE   = 5'h01;
    localparam logic [BST_IR_W-1:0] BST_OP_INT_SCAN = 5'h02;
    localparam logic [BST_IR_W-1:0] BST_OP_CLAMP    = 5'h04;
    localparam logic [BST_IR_W-1:0] BST_OP_HIGHZ    = 5'h05;
    localparam logic [BST_IR_W-1:0] BST_OP_MEMTEST  = 5'h0a;
    localparam logic [BST_IR_W-1:0] BST_OP_IDCODE   = 5'h0c;
    localparam logic [BST_IR_W-1:0] BST_OP_BYPASS   = 5'h1f;
    // memory_selftest_instr and internal scan are not implemented: treated as bypass
    localparam logic [BST_IR_W-1:0] BST_IR_CAPTURE  = 5'h01;

    // test_identification fields; values are arbitrary
    localparam int          BST_ID_VER_LSB  = 28;
    localparam int          BST_ID_PART_LSB = 12;
    localparam int          BST_ID_MFR_LSB  = 1;
    localparam logic [3:0]  BST_ID_VERSION  = 4'h1;
    localparam logic [15:0] BST_ID_PART     = 16'h1234;
    localparam logic [10:0] BST_ID_MFR      = 11'h055;
    localparam logic        BST_ID_FIXED    = 1'b1;
    localparam logic [BST_ID_W-1:0] BST_IDCODE =
        {BST_ID_VERSION, BST_ID_PART, BST_ID_MFR, BST_ID_FIXED};

    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
        logic trst_n;
    } bst_pins_t;

    typedef struct packed {
        logic sel_bs;     // boundary chain between tdi and tdo
        logic sel_id;     // identification register selected
        logic drive_bs;   // pins driven from update cells
        logic highz;      // all outputs released
    } bst_dec_t;

    typedef enum logic [15:0] {
        BST_TLR    = 16'h0001,
        BST_RTI    = 16'h0002,
        BST_SEL_DR = 16'h0004,
        BST_CAP_DR = 16'h0008,
        BST_SH_DR  = 16'h0010,
        BST_EX1_DR = 16'h0020,
        BST_PA_DR  = 16'h0040,
        BST_EX2_DR = 16'h0080,
        BST_UP_DR  = 16'h0100,
        BST_SEL_IR = 16'h0200,
        BST_CAP_IR = 16'h0400,
        BST_SH_IR  = 16'h0800,
        BST_EX1_IR = 16'h1000,
        BST_PA_IR  = 16'h2000,
        BST_EX2_IR = 16'h4000,
        BST_UP_IR  = 16'h8000
    } bst_state_t;

    function automatic bst_dec_t bst_decode(input logic [BST_IR_W-1:0] op);
        bst_dec_t d;
        d = '0;
        unique case (op)
            BST_OP_EXTEST:
            begin
                d.sel_bs   = 1'b1;
                d.drive_bs = 1'b1;
            end
            BST_OP_SAMPLE: d.sel_bs   = 1'b1;
            BST_OP_CLAMP:  d.drive_bs = 1'b1;
            BST_OP_HIGHZ:  d.highz    = 1'b1;
            BST_OP_IDCODE: d.sel_id   = 1'b1;
            default:       d          = '0;
        endcase
        return d;
    endfunction : bst_decode

endpackage : bst_pkg

//--- bst_tap.sv
// bst_tap: test access port controller, instruction, bypass, identification and boundary chain.
// assumes clk_sys runs much faster than tck; pads are resolved from value and enable outside.
`timescale 1ns/1ps

// Behaviour
// RULE1 - sixteen-state controller stepped by tck, steered by tms
// RULE2 - power-on reset forces test-logic-reset, with test reset
// RULE3 - five-bit instruction selects the data register
// RULE4 - undefined codes act as bypass
// RULE5 - extest selects chain, pins driven and captured
// RULE6 - sample selects chain, pins undisturbed
// RULE7 - highz releases all outputs, selects bypass
// RULE8 - clamp drives pins from chain, shifts bypass
// RULE9 - idcode selects the 32-bit identification register
// RULE10 - bypass is one shift stage
// RULE11 - id layout version, part, maker, bit0 one
// RULE12 - chain shifts tdi to tdo, test pins excluded
// RULE13 - four cell kinds chosen per pin function
// RULE14 - chain cells are dedicated test logic
// RULE15 - chain captures pins in parallel on tck rise
// RULE16 - test port idle while functional bus busy
// RULE17 - every functional pin lies in the chain
// RULE18 - bidir data cell followed by its control cell
// RULE19 - tdo changes on tck fall, driven only shifting
module bst_tap
    import bst_pkg::*;
(
    input  wire logic                  clk_sys,
    input  wire logic                  rstn,
    input  wire bst_pins_t             jtag,
    input  wire logic                  bus_busy,
    output logic                       tdo,
    output logic                       tdo_oe,
    input  wire logic [BST_NB-1:0]     core_bd_out,
    input  wire logic [BST_NB-1:0]     core_bd_oe,
    output logic      [BST_NB-1:0]     core_bd_in,
    input  wire logic [BST_NB-1:0]     pad_bd_in,
    output logic      [BST_NB-1:0]     pad_bd_out,
    output logic      [BST_NB-1:0]     pad_bd_oe,
    input  wire logic [BST_NI-1:0]     pad_in,
    output logic      [BST_NI-1:0]     core_in,
    input  wire logic [BST_NO-1:0]     core_out,
    output logic      [BST_NO-1:0]     pad_out,
    output logic      [BST_NO-1:0]     pad_out_oe
);

    logic                     rst_s1_reg;
    logic                     rst_s2_reg;
    logic                     rst_n;
    bst_pins_t                jtag_s1_reg;
    bst_pins_t                jtag_s2_reg;
    logic                     tck_prev_reg;
    logic                     tck_rise;
    logic                     tck_fall;
    logic                     test_reset;
    logic [BST_NB-1:0]        bd_s1_reg;
    logic [BST_NB-1:0]        bd_s2_reg;
    logic [BST_NI-1:0]        in_s1_reg;
    logic [BST_NI-1:0]        in_s2_reg;
    bst_state_t               state_reg;
    bst_state_t               state_next;
    logic [BST_IR_W-1:0]      ir_shift_reg;
    logic [BST_IR_W-1:0]      ir_reg;
    bst_dec_t                 dec;
    logic                     byp_reg;
    logic [BST_ID_W-1:0]      id_shift_reg;
    logic [BST_CHAIN_LEN-1:0] bs_shift_reg;
    logic [BST_CHAIN_LEN-1:0] bs_upd_reg;
    logic [BST_CHAIN_LEN-1:0] bs_cap;
    logic                     dr_out;
    logic                     tdo_reg;
    logic                     tdo_oe_reg;
    logic [BST_NB-1:0]        pad_bd_out_reg;
    logic [BST_NB-1:0]        pad_bd_oe_reg;
    logic [BST_NB-1:0]        core_bd_in_reg;
    logic [BST_NI-1:0]        core_in_reg;
    logic [BST_NO-1:0]        pad_out_reg;
    logic [BST_NO-1:0]        pad_out_oe_reg;

    // reset release through two stages; this is the power-on reset of the test logic
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            rst_s1_reg <= 1'b0;
            rst_s2_reg <= 1'b0;
        end
        else
        begin
            rst_s1_reg <= 1'b1;
            rst_s2_reg <= rst_s1_reg;
        end
    end
    assign rst_n = rst_s2_reg;

    // test port pins synchronised
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            jtag_s1_reg  <= '0;
            jtag_s2_reg  <= '0;
            tck_prev_reg <= 1'b0;
        end
        else
        begin
            jtag_s1_reg  <= jtag;
            jtag_s2_reg  <= jtag_s1_reg;
            tck_prev_reg <= jtag_s2_reg.tck;
        end
    end

    // pad inputs synchronised
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bd_s1_reg <= '0;
            bd_s2_reg <= '0;
            in_s1_reg <= '0;
            in_s2_reg <= '0;
        end
        else
        begin
            bd_s1_reg <= pad_bd_in;
            bd_s2_reg <= bd_s1_reg;
            in_s1_reg <= pad_in;
            in_s2_reg <= in_s1_reg;
        end
    end

    // tck edges are ignored while the functional bus runs cycles
    assign tck_rise   = jtag_s2_reg.tck & ~tck_prev_reg & ~bus_busy;   // see RULE16
    assign tck_fall   = ~jtag_s2_reg.tck & tck_prev_reg & ~bus_busy;   // see RULE16
    assign test_reset = ~jtag_s2_reg.trst_n;                           // see RULE2

    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)   // see RULE1
            BST_TLR:    state_next = jtag_s2_reg.tms ? BST_TLR    : BST_RTI;
            BST_RTI:    state_next = jtag_s2_reg.tms ? BST_SEL_DR : BST_RTI;
            BST_SEL_DR: state_next = jtag_s2_reg.tms ? BST_SEL_IR : BST_CAP_DR;
            BST_CAP_DR: state_next = jtag_s2_reg.tms ? BST_EX1_DR : BST_SH_DR;
            BST_SH_DR:  state_next = jtag_s2_reg.tms ? BST_EX1_DR : BST_SH_DR;
            BST_EX1_DR: state_next = jtag_s2_reg.tms ? BST_UP_DR  : BST_PA_DR;
            BST_PA_DR:  state_next = jtag_s2_reg.tms ? BST_EX2_DR : BST_PA_DR;
            BST_EX2_DR: state_next = jtag_s2_reg.tms ? BST_UP_DR  : BST_SH_DR;
            BST_UP_DR:  state_next = jtag_s2_reg.tms ? BST_SEL_DR : BST_RTI;
            BST_SEL_IR: state_next = jtag_s2_reg.tms ? BST_TLR    : BST_CAP_IR;
            BST_CAP_IR: state_next = jtag_s2_reg.tms ? BST_EX1_IR : BST_SH_IR;
            BST_SH_IR:  state_next = jtag_s2_reg.tms ? BST_EX1_IR : BST_SH_IR;
            BST_EX1_IR: state_next = jtag_s2_reg.tms ? BST_UP_IR  : BST_PA_IR;
            BST_PA_IR:  state_next = jtag_s2_reg.tms ? BST_EX2_IR : BST_PA_IR;
            BST_EX2_IR: state_next = jtag_s2_reg.tms ? BST_UP_IR  : BST_SH_IR;
            BST_UP_IR:  state_next = jtag_s2_reg.tms ? BST_SEL_DR : BST_RTI;
            default:    state_next = BST_TLR;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            state_reg <= BST_TLR;                       // see RULE2
        else if (test_reset)
            state_reg <= BST_TLR;                       // see RULE2
        else if (tck_rise)
            state_reg <= state_next;                    // see RULE1
    end

    // instruction shift on rise, update on fall
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ir_shift_reg <= BST_IR_CAPTURE;
            ir_reg       <= BST_OP_IDCODE;
        end
        else if (test_reset || state_reg == BST_TLR)
        begin
            ir_shift_reg <= BST_IR_CAPTURE;
            ir_reg       <= BST_OP_IDCODE;
        end
        else
        begin
            if (tck_rise && state_reg == BST_CAP_IR)
                ir_shift_reg <= BST_IR_CAPTURE;
            else if (tck_rise && state_reg == BST_SH_IR)
                ir_shift_reg <= {jtag_s2_reg.tdi, ir_shift_reg[BST_IR_W-1:1]};   // see RULE3
            if (tck_fall && state_reg == BST_UP_IR)
                ir_reg <= ir_shift_reg;                                           // see RULE3
        end
    end

    // unlisted codes decode to no selection, which leaves bypass in the path
    assign dec = bst_decode(ir_reg);   // see RULE4

    // bypass stage
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            byp_reg <= 1'b0;
        else if (tck_rise && state_reg == BST_CAP_DR)
            byp_reg <= 1'b0;
        else if (tck_rise && state_reg == BST_SH_DR)
            byp_reg <= jtag_s2_reg.tdi;   // see RULE10
    end

    // identification register; fixed fields reloaded at every capture
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            id_shift_reg <= BST_IDCODE;
        else if (tck_rise && state_reg == BST_CAP_DR)
            id_shift_reg <= BST_IDCODE;                                          // see RULE11
        else if (tck_rise && state_reg == BST_SH_DR && dec.sel_id)
            id_shift_reg <= {jtag_s2_reg.tdi, id_shift_reg[BST_ID_W-1:1]};       // see RULE9
    end

    // capture vector: bidir data, its control, inputs, outputs
    genvar gi;
    generate
        for (gi = 0; gi < BST_NB; gi++)
        begin : g_bd_cap
            assign bs_cap[2 * gi]     = bd_s2_reg[gi];       // see RULE18
            assign bs_cap[2 * gi + 1] = pad_bd_oe_reg[gi];   // see RULE18
        end
        for (gi = 0; gi < BST_NI; gi++)
        begin : g_in_cap
            assign bs_cap[BST_IN_BASE + gi] = in_s2_reg[gi];     // see RULE13
        end
        for (gi = 0; gi < BST_NO; gi++)
        begin : g_out_cap
            assign bs_cap[BST_OUT_BASE + gi] = pad_out_reg[gi];  // see RULE13
        end
    endgenerate

    // boundary chain, cell 0 nearest tdo
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            bs_shift_reg <= '0;
        else if (tck_rise && state_reg == BST_CAP_DR && dec.sel_bs)
            bs_shift_reg <= bs_cap;                                              // see RULE15
        else if (tck_rise && state_reg == BST_SH_DR && dec.sel_bs)
            bs_shift_reg <= {jtag_s2_reg.tdi, bs_shift_reg[BST_CHAIN_LEN-1:1]};  // see RULE12
    end

    // update cells; loaded by sample preload or extest, kept through clamp
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            bs_upd_reg <= '0;
        else if (test_reset || state_reg == BST_TLR)
            bs_upd_reg <= '0;
        else if (tck_fall && state_reg == BST_UP_DR && dec.sel_bs)
            bs_upd_reg <= bs_shift_reg;                   // see RULE6
    end

    always_comb
    begin
        if (dec.sel_bs)
            dr_out = bs_shift_reg[0];                     // see RULE12
        else if (dec.sel_id)
            dr_out = id_shift_reg[0];                     // see RULE9
        else
            dr_out = byp_reg;                             // see RULE4
    end

    // tdo moves on the falling edge, enabled only while shifting
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tdo_reg    <= 1'b0;
            tdo_oe_reg <= 1'b0;
        end
        else if (test_reset)
        begin
            tdo_reg    <= 1'b0;
            tdo_oe_reg <= 1'b0;
        end
        else if (tck_fall)
        begin
            tdo_oe_reg <= (state_reg == BST_SH_DR) || (state_reg == BST_SH_IR);   // see RULE19
            if (state_reg == BST_SH_DR)
                tdo_reg <= dr_out;                                                // see RULE19
            else if (state_reg == BST_SH_IR)
                tdo_reg <= ir_shift_reg[0];                                       // see RULE19
        end
    end

    // pad drivers: functional path unless a drive or highz instruction is active
    generate
        for (gi = 0; gi < BST_NB; gi++)
        begin : g_bd_pad
            always_ff @(posedge clk_sys or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    pad_bd_out_reg[gi] <= 1'b0;
                    pad_bd_oe_reg[gi]  <= 1'b0;
                    core_bd_in_reg[gi] <= 1'b0;
                end
                else
                begin
                    core_bd_in_reg[gi] <= bd_s2_reg[gi];                 // see RULE14
                    if (dec.highz)
                    begin
                        pad_bd_out_reg[gi] <= core_bd_out[gi];
                        pad_bd_oe_reg[gi]  <= 1'b0;                      // see RULE7
                    end
                    else if (dec.drive_bs)
                    begin
                        pad_bd_out_reg[gi] <= bs_upd_reg[2 * gi];        // see RULE5
                        pad_bd_oe_reg[gi]  <= bs_upd_reg[2 * gi + 1];    // see RULE8
                    end
                    else
                    begin
                        pad_bd_out_reg[gi] <= core_bd_out[gi];           // see RULE17
                        pad_bd_oe_reg[gi]  <= core_bd_oe[gi];
                    end
                end
            end
        end
        for (gi = 0; gi < BST_NI; gi++)
        begin : g_in_pad
            always_ff @(posedge clk_sys or negedge rst_n)
            begin
                if (!rst_n)
                    core_in_reg[gi] <= 1'b0;
                else
                    core_in_reg[gi] <= in_s2_reg[gi];                    // see RULE17
            end
        end
        for (gi = 0; gi < BST_NO; gi++)
        begin : g_out_pad
            always_ff @(posedge clk_sys or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    pad_out_reg[gi]    <= 1'b0;
                    pad_out_oe_reg[gi] <= 1'b0;
                end
                else if (dec.highz)
                begin
                    pad_out_reg[gi]    <= core_out[gi];
                    pad_out_oe_reg[gi] <= 1'b0;                          // see RULE7
                end
                else if (dec.drive_bs)
                begin
                    pad_out_reg[gi]    <= bs_upd_reg[BST_OUT_BASE + gi]; // see RULE8
                    pad_out_oe_reg[gi] <= 1'b1;
                end
                else
                begin
                    pad_out_reg[gi]    <= core_out[gi];                  // see RULE17
                    pad_out_oe_reg[gi] <= 1'b1;
                end
            end
        end
    endgenerate

    assign tdo        = tdo_reg;
    assign tdo_oe     = tdo_oe_reg;
    assign pad_bd_out = pad_bd_out_reg;
    assign pad_bd_oe  = pad_bd_oe_reg;
    assign core_bd_in = core_bd_in_reg;
    assign core_in    = core_in_reg;
    assign pad_out    = pad_out_reg;
    assign pad_out_oe = pad_out_oe_reg;

endmodule : bst_tap

//--- bst_tap_monitor.sv
// bst_tap_monitor: port-level assertions for the boundary-scan test port.
// assumes the bench drives tck slower than 6 clk_sys periods; bound below.
`timescale 1ns/1ps
module bst_tap_monitor
    import bst_pkg::*;
(
    input wire logic              clk_sys,
    input wire logic              rstn,
    input wire bst_pins_t         jtag,
    input wire logic              bus_busy,
    input wire logic              tdo,
    input wire logic              tdo_oe,
    input wire logic [BST_NB-1:0] core_bd_out,
    input wire logic [BST_NB-1:0] core_bd_oe,
    input wire logic [BST_NB-1:0] core_bd_in,
    input wire logic [BST_NB-1:0] pad_bd_in,
    input wire logic [BST_NB-1:0] pad_bd_out,
    input wire logic [BST_NB-1:0] pad_bd_oe,
    input wire logic [BST_NI-1:0] pad_in,
    input wire logic [BST_NI-1:0] core_in,
    input wire logic [BST_NO-1:0] core_out,
    input wire logic [BST_NO-1:0] pad_out,
    input wire logic [BST_NO-1:0] pad_out_oe
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    property p_tdo_on_fall; $changed(tdo) |-> !$past(jtag.tck, 2); endproperty
    a_tdo_on_fall: assert property (p_tdo_on_fall) else $error("tdo moved after tck rise");
    property p_oe_rise; $rose(tdo_oe) |-> !$past(jtag.tck, 2); endproperty
    a_oe_rise: assert property (p_oe_rise) else $error("tdo_oe rose after tck rise");
    property p_oe_fall; $fell(tdo_oe) |-> !$past(jtag.tck, 2); endproperty
    a_oe_fall: assert property (p_oe_fall) else $error("tdo_oe fell after tck rise");
    property p_busy_freeze; bus_busy[*6] |-> $stable(tdo) && $stable(tdo_oe); endproperty
    a_busy_freeze: assert property (p_busy_freeze) else $error("test port moved while busy");
    property p_in_follow; ($stable(pad_in))[*8] |-> core_in == pad_in; endproperty
    a_in_follow: assert property (p_in_follow) else $error("core_in not following pins");
    property p_bd_follow; ($stable(pad_bd_in))[*8] |-> core_bd_in == pad_bd_in; endproperty
    a_bd_follow: assert property (p_bd_follow) else $error("core_bd_in not following");
    property p_highz_all; pad_out_oe == '0 |-> pad_bd_oe == '0; endproperty
    a_highz_all: assert property (p_highz_all) else $error("bidir driven in highz");
    property p_oe_uniform; pad_out_oe == '0 || pad_out_oe == '1; endproperty
    a_oe_uniform: assert property (p_oe_uniform) else $error("output enables split");
    property p_trst; (!jtag.trst_n)[*6] |-> !tdo_oe && !tdo && pad_out_oe == '1; endproperty
    a_trst: assert property (p_trst) else $error("test reset not applied");
    property p_rst_quiet; $rose(rstn) |-> (!tdo_oe && !tdo)[*4]; endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("tdo active after reset");

    c_shift: cover property ($rose(tdo_oe));
    c_busy: cover property (bus_busy[*6]);
    c_highz: cover property (pad_out_oe == '0);
    c_trst: cover property (!jtag.trst_n);
endmodule : bst_tap_monitor

bind bst_tap bst_tap_monitor i_bst_tap_monitor (.clk_sys(clk_sys), .rstn(rstn), .jtag(jtag),
    .bus_busy(bus_busy), .tdo(tdo), .tdo_oe(tdo_oe), .core_bd_out(core_bd_out),
    .core_bd_oe(core_bd_oe), .core_bd_in(core_bd_in), .pad_bd_in(pad_bd_in),
    .pad_bd_out(pad_bd_out), .pad_bd_oe(pad_bd_oe), .pad_in(pad_in), .core_in(core_in),
    .core_out(core_out), .pad_out(pad_out), .pad_out_oe(pad_out_oe));

//--- bst_tap_tb.sv
// bst_tap_tb: self-checking bench with a scan model of the test port.
// assumes bst_tester stands on the far side; pads resolved here.
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin n_checks++; if ((gt) !== (ex)) begin error_cnt++; \
    $display("MISMATCH %s exp=%h got=%h", nm, ex, gt); end end
module bst_tap_tb;
    import bst_pkg::*;
    logic                     clk_sys, rstn, bus_busy, tdo, tdo_oe;
    bst_pins_t                jtag;
    logic [BST_NB-1:0]        core_bd_out, core_bd_oe, core_bd_in, pad_bd_in, pad_bd_out;
    logic [BST_NB-1:0]        pad_bd_oe, ext_bd, e_oe, e_out;
    logic [BST_NI-1:0]        pad_in, core_in;
    logic [BST_NO-1:0]        core_out, pad_out, pad_out_oe, e_o;
    logic [BST_CHAIN_LEN-1:0] upd, cap;
    logic [BST_IR_W-1:0]      op;
    logic [BST_IR_W-1:0]      ops [9];
    logic [63:0]              din, dout;
    logic [39:0]              ev;
    logic [31:0]              rnd;
    int                       error_cnt, n_checks, len, seed, k, j;

    // bidir pins: device drive wins, else the board level
    assign pad_bd_in = (pad_bd_oe & pad_bd_out) | (~pad_bd_oe & ext_bd);

    bst_tap i_bst_tap (.clk_sys(clk_sys), .rstn(rstn), .jtag(jtag), .bus_busy(bus_busy),
        .tdo(tdo), .tdo_oe(tdo_oe), .core_bd_out(core_bd_out), .core_bd_oe(core_bd_oe),
        .core_bd_in(core_bd_in), .pad_bd_in(pad_bd_in), .pad_bd_out(pad_bd_out),
        .pad_bd_oe(pad_bd_oe), .pad_in(pad_in), .core_in(core_in), .core_out(core_out),
        .pad_out(pad_out), .pad_out_oe(pad_out_oe));
    // released tdo reads as the inverse at the tester
    bst_tester i_bst_tester (.jtag(jtag), .tdo(tdo_oe ? tdo : ~tdo));

    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task print_verdict;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : print_verdict

    // ir or dr scan from idle back to idle, optional bus burst mid-shift
    task scan(input logic is_ir, input int n, input logic busy_mid);
        logic so;
        int   i;
        i_bst_tester.tick(1'b1, 1'b1, so);
        if (is_ir)
            i_bst_tester.tick(1'b1, 1'b1, so);
        i_bst_tester.tick(1'b0, 1'b1, so);
        i_bst_tester.tick(1'b0, 1'b1, so);
        for (i = 0; i < n; i++)
        begin
            if (busy_mid && i == 3)
            begin
                repeat (5) @(posedge clk_sys);
                #1 bus_busy = 1'b1;
                i_bst_tester.tick(1'b1, 1'b0, so);
                i_bst_tester.tick(1'b1, 1'b0, so);
                repeat (4) @(posedge clk_sys);
                #1 bus_busy = 1'b0;
            end
            i_bst_tester.tick(i == n - 1, din[i], so);
            dout[i] = so;
            if (i == 0) `CHK("tdo_oe shift", 1'b1, tdo_oe)
        end
        i_bst_tester.tick(1'b1, 1'b1, so);
        i_bst_tester.tick(1'b0, 1'b1, so);
        repeat (6) @(posedge clk_sys);
        `CHK("tdo_oe idle", 1'b0, tdo_oe)
    endtask : scan

    // expected pads and capture for the current instruction
    task exp_model;
        logic drv, hz;
        drv = (op == BST_OP_EXTEST) || (op == BST_OP_CLAMP);
        hz  = (op == BST_OP_HIGHZ);
        for (k = 0; k < BST_NB; k++)
        begin
            e_oe[k]      = hz ? 1'b0 : drv ? upd[2*k+1] : core_bd_oe[k];
            e_out[k]     = drv ? upd[2*k] : core_bd_out[k];
            cap[2*k]     = e_oe[k] ? e_out[k] : ext_bd[k];
            cap[2*k+1]   = e_oe[k];
        end
        for (k = 0; k < BST_NO; k++)
        begin
            e_o[k] = drv ? upd[BST_OUT_BASE+k] : core_out[k];
            cap[BST_OUT_BASE+k] = e_o[k];
        end
        cap[BST_IN_BASE +: BST_NI] = pad_in;
        len = (op == BST_OP_EXTEST || op == BST_OP_SAMPLE) ? BST_CHAIN_LEN :
              (op == BST_OP_IDCODE) ? BST_ID_W : 1;
        `CHK("pad_bd_oe", e_oe, pad_bd_oe)
        `CHK("pad_bd_out", e_out & e_oe, pad_bd_out & e_oe)
        `CHK("pad_out_oe", {BST_NO{~hz}}, pad_out_oe)
        if (!hz) `CHK("pad_out", e_o, pad_out)
        `CHK("core_in", pad_in, core_in)
        `CHK("core_bd_in", (e_oe & e_out) | (~e_oe & ext_bd), core_bd_in)
    endtask : exp_model

    initial
    begin
        seed = 32'he3d9;
        rstn = 1'b0;
        bus_busy = 1'b0;
        rnd = $random(seed);
        {core_bd_out, core_bd_oe, core_out, pad_in, ext_bd} = rnd[15:0];
        ops = '{BST_OP_SAMPLE, BST_OP_EXTEST, BST_OP_CLAMP, BST_OP_HIGHZ, BST_OP_IDCODE,
                BST_OP_BYPASS, BST_OP_INT_SCAN, BST_OP_MEMTEST, 5'h13};
        repeat (6) @(posedge clk_sys);
        #1 rstn = 1'b1;
        repeat (8) @(posedge clk_sys);
        #1 i_bst_tester.goto_idle();
        din = '1;
        scan(1'b0, 32, 1'b0);
        `CHK("id power-on", {BST_ID_VERSION, BST_ID_PART, BST_ID_MFR, 1'b1}, dout[31:0])
        upd = '0;
        for (j = 0; j < 9; j++)
        begin
            @(posedge clk_sys);
            rnd = $random(seed);
            #1 {core_bd_out, core_bd_oe, core_out, pad_in, ext_bd} = rnd[15:0];
            op = ops[j];
            din = {$random(seed), $random(seed)};
            din[4:0] = op;
            scan(1'b1, 5, 1'b0);
            `CHK("ir capture", BST_IR_CAPTURE, dout[4:0])
            exp_model();
            din = {$random(seed), $random(seed)};
            scan(1'b0, 40, op == BST_OP_BYPASS);
            for (k = 0; k < 40; k++)
                ev[k] = (k >= len) ? din[k-len] : (len == 1) ? 1'b0 :
                        (len == BST_ID_W) ? BST_IDCODE[k] : cap[k];
            `CHK("dr scan", ev, dout[39:0])
            if (len == BST_CHAIN_LEN)
                upd = din[40-BST_CHAIN_LEN +: BST_CHAIN_LEN];
        end
        i_bst_tester.treset();
        op = BST_OP_IDCODE;
        upd = '0;
        exp_model();
        i_bst_tester.tick(1'b0, 1'b1, dout[0]);
        din = '0;
        scan(1'b0, 32, 1'b0);
        `CHK("id after trst", BST_IDCODE, dout[31:0])
        print_verdict();
    end

    initial
    begin
        #400000;
        error_cnt++;
        print_verdict();
    end
endmodule : bst_tap_tb

//--- bst_tester.sv
// bst_tester: behavioural boundary-scan tester driving the test port pins.
// assumes callers step it from one process; tck stands low between frames.
`timescale 1ns/1ps
module bst_tester
    import bst_pkg::*;
(
    output bst_pins_t jtag,
    input wire logic  tdo
);
    initial jtag = '{tck: 1'b0, tms: 1'b1, tdi: 1'b1, trst_n: 1'b1};

    // one 80 ns tck period; tdo taken at the rise
    task tick(input logic ms, input logic di, output logic so);
        jtag.tms = ms;
        jtag.tdi = di;
        #30 jtag.tck = 1'b1;
        so = tdo;
        #40 jtag.tck = 1'b0;
        #10;
    endtask : tick

    // five tms highs reach reset from any state, then idle
    task goto_idle;
        logic so;
        repeat (5) tick(1'b1, 1'b1, so);
        tick(1'b0, 1'b1, so);
    endtask : goto_idle

    task treset;
        jtag.trst_n = 1'b0;
        #200 jtag.trst_n = 1'b1;
        #100;
    endtask : treset
endmodule : bst_tester
